/* File: dv/async_static_ram_port_bench.sv */
// Self-checking bench: controller against a behavioural memory.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
module async_static_ram_port_bench;
  reg         clk_sys = 1'b0;
  reg         rst = 1'b1;
  reg         req_valid = 1'b0;
  reg         req_write = 1'b0;
  reg  [14:0] req_addr = 15'h0000;
  reg  [7:0]  req_wdata = 8'h00;
  reg  [7:0]  last = 8'h00;
  wire        req_ready, rsp_valid, mem_select_n, mem_strobe_n, mem_gate_n, data_oe_n, drive;
  wire [7:0]  rsp_rdata, data_out, q, bus;
  wire [14:0] mem_addr;
  int         num_errors = 0;
  int         n_compared = 0;
  always #5 clk_sys = ~clk_sys;
  // A released bus shows the inverse of its last driven value
  always @*
    if (!data_oe_n) last = data_out;
    else if (drive) last = q;
  assign bus = !data_oe_n ? data_out : drive ? q : ~last;
  sram_ctl sram_ctl_inst (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_select_n(mem_select_n),
    .mem_strobe_n(mem_strobe_n), .mem_gate_n(mem_gate_n), .mem_addr(mem_addr),
    .data_out(data_out), .data_oe_n(data_oe_n), .data_in(bus));
  sram_mem_model sram_mem_model_inst (.sel_n(mem_select_n), .we_n(mem_strobe_n),
    .oe_n(mem_gate_n), .a(mem_addr), .d_in(bus), .q(q), .drive(drive));
  task req(input w, input [14:0] a, input [7:0] d);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk_sys);
    while (req_ready !== 1'b1) @(posedge clk_sys);
    req_valid <= 1'b0;
  endtask
  task rd_chk(input [14:0] a, input [7:0] e);
    req(1'b0, a, 8'h00);
    @(posedge clk_sys);
    while (rsp_valid !== 1'b1) @(posedge clk_sys);
    n_compared++;
    if (rsp_rdata !== e)
    begin
      num_errors++;
      $display("MISMATCH rsp_rdata at %h exp %h got %h", a, e, rsp_rdata);
    end
  endtask
  // Lowest and highest address, written back to back
  task t_edges;
    req(1'b1, 15'h0000, 8'ha5);
    req(1'b1, 15'h7fff, 8'h5a);
    rd_chk(15'h0000, 8'ha5);
    rd_chk(15'h7fff, 8'h5a);
  endtask
  task t_overwrite;
    req(1'b1, 15'h1234, 8'h3c);
    req(1'b1, 15'h1234, 8'hc3);
    rd_chk(15'h1234, 8'hc3);
    rd_chk(15'h0000, 8'ha5);
  endtask
  // Reset in mid-run idles the pins and leaves the memory contents alone
  task t_reset;
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    n_compared++;
    if (mem_select_n !== 1'b1 || req_ready !== 1'b1)
    begin
      num_errors++;
      $display("MISMATCH select_ready in reset exp 11 got %b%b", mem_select_n, req_ready);
    end
    rst <= 1'b0;
    rd_chk(15'h1234, 8'hc3);
  endtask
  task print_verdict;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    t_edges;
    t_overwrite;
    t_reset;
    print_verdict;
  end
  initial
  begin
    #20000;
    num_errors++;
    print_verdict;
  end
endmodule // async_static_ram_port_bench

/* File: dv/sram_ctl_asserts.sv */
// Pin timing checks for the static memory controller.
// Assumes it is bound to every controller instance.
`timescale 1ns/1ps
module sram_ctl_asserts (
  // Clock, reset and user side
  input wire        clk_sys,
  input wire        rst,
  input wire        req_valid,
  input wire        req_write,
  input wire        req_ready,
  input wire        rsp_valid,
  // Memory pins
  input wire        mem_select_n,
  input wire        mem_strobe_n,
  input wire        mem_gate_n,
  input wire [14:0] mem_addr,
  input wire [7:0]  data_out,
  input wire        data_oe_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire take = req_valid && req_ready;
  strobe_in_select_a: assert property (!mem_strobe_n |-> !mem_select_n)
    else $error("strobe without select");
  write_start_a: assert property (take && req_write |-> ##1 !mem_strobe_n && !data_oe_n)
    else $error("write did not start");
  pulse_len_a: assert property ($fell(mem_strobe_n) |-> !mem_strobe_n[*5] ##1 mem_strobe_n)
    else $error("strobe width wrong");
  end_order_a: assert property ($rose(mem_strobe_n) |-> !mem_select_n ##1 mem_select_n)
    else $error("select rose with strobe");
  data_hold_a: assert property ($rose(mem_strobe_n) |-> !data_oe_n && $stable(data_out))
    else $error("data not held");
  no_clash_a: assert property (!data_oe_n |-> mem_gate_n)
    else $error("drive with gate low");
  addr_steady_a: assert property (!mem_select_n && $past(!mem_select_n) |-> $stable(mem_addr))
    else $error("address moved");
  read_answer_a: assert property (take && !req_write |-> ##9 rsp_valid)
    else $error("read answer late");
  cover property (rsp_valid);
  cover property ($rose(mem_strobe_n));
  cover property (take ##[1:20] take);
endmodule // sram_ctl_asserts
bind sram_ctl sram_ctl_asserts sram_ctl_asserts_inst (.clk_sys(clk_sys), .rst(rst),
  .req_valid(req_valid), .req_write(req_write), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .mem_select_n(mem_select_n), .mem_strobe_n(mem_strobe_n),
  .mem_gate_n(mem_gate_n), .mem_addr(mem_addr), .data_out(data_out), .data_oe_n(data_oe_n));

/* File: dv/sram_mem_model.sv */
// Behavioural byte-wide static memory facing the controller.
// Assumes the bench resolves the shared data bus.
`timescale 1ns/1ps
module sram_mem_model (
  // Memory pins
  input  wire        sel_n,
  input  wire        we_n,
  input  wire        oe_n,
  input  wire [14:0] a,
  input  wire [7:0]  d_in,
  // Read side
  output wire [7:0]  q,
  output wire        drive
);
  reg [7:0] mem [0:32767];
  assign drive = !sel_n && we_n && !oe_n;
  assign q = mem[a];
  // Byte lands when the select and strobe overlap ends
  always @(posedge (sel_n | we_n))
    mem[a] <= d_in;
endmodule // sram_mem_model

/* File: rtl/sram_ctl.v */
// Host-side controller that drives an asynchronous byte-wide static memory.
// Assumes the memory is wired to the pin ports; the bench resolves the data bus
// from data_out and data_oe_n.
`timescale 1ns/1ps
`include "sram_ctl_map.vh"
module sram_ctl #(
  parameter ADDR_WIDTH = `ADDR_WIDTH,
  parameter DATA_WIDTH = `DATA_WIDTH
) (
  // Clock and reset
  input  wire                  clk_sys,
  input  wire                  rst,
  // User request
  input  wire                  req_valid,
  input  wire                  req_write,
  input  wire [ADDR_WIDTH-1:0] req_addr,
  input  wire [DATA_WIDTH-1:0] req_wdata,
  output wire                  req_ready,
  // User answer
  output reg                   rsp_valid,
  output reg  [DATA_WIDTH-1:0] rsp_rdata,
  // Memory pins
  output reg                   mem_select_n,
  output reg                   mem_strobe_n,
  output reg                   mem_gate_n,
  output reg  [ADDR_WIDTH-1:0] mem_addr,
  output reg  [DATA_WIDTH-1:0] data_out,
  output reg                   data_oe_n,
  input  wire [DATA_WIDTH-1:0] data_in
);
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_READ  = 3'h1;
  localparam [2:0] ST_RFLT  = 3'h2;
  localparam [2:0] ST_WRITE = 3'h3;
  localparam [2:0] ST_WHOLD = 3'h4;
  // Cycle counts, cut to the counter width on purpose
  localparam [31:0]           READ_CNT_FULL  = `READ_ACCESS_CYC + 2;
  localparam [31:0]           FLT_CNT_FULL   = `OUT_FLOAT_CYC;
  localparam [31:0]           WRITE_CNT_FULL = `WRITE_PULSE_CYC;
  localparam [31:0]           HOLD_CNT_FULL  = `ADDR_HOLD_CYC;
  localparam [`CNT_WIDTH-1:0] READ_CNT       = READ_CNT_FULL[`CNT_WIDTH-1:0];
  localparam [`CNT_WIDTH-1:0] FLT_CNT        = FLT_CNT_FULL[`CNT_WIDTH-1:0];
  localparam [`CNT_WIDTH-1:0] WRITE_CNT      = WRITE_CNT_FULL[`CNT_WIDTH-1:0];
  localparam [`CNT_WIDTH-1:0] HOLD_CNT       = HOLD_CNT_FULL[`CNT_WIDTH-1:0];
  localparam [`CNT_WIDTH-1:0] ONE            = 4'h1;
  localparam [`CNT_WIDTH-1:0] ZERO           = 4'h0;

  // Sequencer
  reg  [2:0]            state;
  reg  [`CNT_WIDTH-1:0] count;
  reg  [2:0]            next_state;
  reg  [`CNT_WIDTH-1:0] next_count;
  wire                  count_done;
  // Next values of the answer and the pins
  reg                   next_rsp_valid;
  reg  [DATA_WIDTH-1:0] next_rsp_rdata;
  reg                   next_select_n;
  reg                   next_strobe_n;
  reg                   next_gate_n;
  reg  [ADDR_WIDTH-1:0] next_addr;
  reg  [DATA_WIDTH-1:0] next_data_out;
  reg                   next_data_oe_n;
  // Pin data after the synchroniser
  wire [DATA_WIDTH-1:0] data_sync;

  // Pin data passes two flip-flops before it is captured
  sync_2ff #(
    .WIDTH (DATA_WIDTH)
  ) sync_2ff_inst (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (data_in),
    .q       (data_sync)
  );

  assign req_ready = (state == ST_IDLE);

  assign count_done = (count == ONE);

  // Next values; every register except rsp_valid keeps its level unless a state moves it; rsp_valid falls back to 0
  always @*
  begin
    next_state     = state;
    next_count     = count;
    next_rsp_valid = 1'b0;
    next_rsp_rdata = rsp_rdata;
    next_select_n  = mem_select_n;
    next_strobe_n  = mem_strobe_n;
    next_gate_n    = mem_gate_n;
    next_addr      = mem_addr;
    next_data_out  = data_out;
    next_data_oe_n = data_oe_n;
    case (state)
      ST_IDLE:
      begin
        if (req_valid)
        begin
          // Address set together with select fall
          next_addr     = req_addr;
          next_select_n = 1'b0;
          if (req_write)
          begin
            // Gate stays high so the memory floats before we drive
            next_gate_n    = 1'b1;
            next_strobe_n  = 1'b0;
            next_data_out  = req_wdata;
            next_data_oe_n = 1'b0;
            next_count     = WRITE_CNT;
            next_state     = ST_WRITE;
          end
          else
          begin
            next_strobe_n  = 1'b1;
            next_gate_n    = 1'b0;
            next_data_oe_n = 1'b1;
            next_count     = READ_CNT;
            next_state     = ST_READ;
          end
        end
      end
      ST_READ:
      begin
        if (count_done)
        begin
          // Synchronised byte is two cycles old, still past the access time
          next_rsp_rdata = data_sync;
          next_rsp_valid = 1'b1;
          next_gate_n    = 1'b1;
          next_select_n  = 1'b1;
          next_count     = FLT_CNT;
          next_state     = ST_RFLT;
        end
        else
          next_count = count - ONE;
      end
      ST_RFLT:
      begin
        // Wait until the memory has released the bus
        if (count_done)
          next_state = ST_IDLE;
        else
          next_count = count - ONE;
      end
      ST_WRITE:
      begin
        if (count_done)
        begin
          // Strobe alone ends the write; select rises one cycle later
          next_strobe_n = 1'b1;
          next_count    = HOLD_CNT;
          next_state    = ST_WHOLD;
        end
        else
          next_count = count - ONE;
      end
      ST_WHOLD:
      begin
        // Data and address held past the terminating edge
        if (count_done)
        begin
          next_select_n  = 1'b1;
          next_data_oe_n = 1'b1;
          next_state     = ST_IDLE;
        end
        else
          next_count = count - ONE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  // Sequencer registers
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      count <= ZERO;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
    end
  end

  // User answer registers
  // Read byte holds until the next read answer
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= {DATA_WIDTH{1'b0}};
    end
    else
    begin
      rsp_valid <= next_rsp_valid;
      rsp_rdata <= next_rsp_rdata;
    end
  end

  // Memory pin registers; select high in reset keeps the memory in standby
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mem_select_n <= 1'b1;
      mem_strobe_n <= 1'b1;
      mem_gate_n   <= 1'b1;
      mem_addr     <= {ADDR_WIDTH{1'b0}};
      data_out     <= {DATA_WIDTH{1'b0}};
      data_oe_n    <= 1'b1;
    end
    else
    begin
      mem_select_n <= next_select_n;
      mem_strobe_n <= next_strobe_n;
      mem_gate_n   <= next_gate_n;
      mem_addr     <= next_addr;
      data_out     <= next_data_out;
      data_oe_n    <= next_data_oe_n;
    end
  end
endmodule // sram_ctl

/* File: rtl/sram_ctl_map.vh */
// Constants for the static memory port controller.
// Assumes a 100 MHz system clock; times are in ns, counts in clk_sys cycles.
`ifndef SRAM_CTL_MAP_VH
`define SRAM_CTL_MAP_VH
`define CLK_PERIOD_NS        10
`define READ_ACCESS_NS       55
`define OUT_FLOAT_NS         20
`define WRITE_PULSE_NS       40
`define DATA_SETUP_TIME_NS   25
`define WRITE_FLOAT_DELAY_NS 20
`define ADDR_HOLD_NS         10
// Least times round up to whole cycles
`define CYC_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_ACCESS_CYC      `CYC_UP(`READ_ACCESS_NS)
`define OUT_FLOAT_CYC        `CYC_UP(`OUT_FLOAT_NS)
`define WRITE_PULSE_CYC      `CYC_UP(`WRITE_FLOAT_DELAY_NS + `DATA_SETUP_TIME_NS)
`define DATA_SETUP_CYC       `CYC_UP(`DATA_SETUP_TIME_NS)
`define ADDR_HOLD_CYC        `CYC_UP(`ADDR_HOLD_NS)
`define ADDR_WIDTH           15
`define DATA_WIDTH           8
`define CNT_WIDTH            4
`endif

/* File: rtl/sync_2ff.v */
// Two flip-flop synchroniser for a bus of pin inputs.
// Assumes the inputs are asynchronous to clk_sys.
`timescale 1ns/1ps
module sync_2ff #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             rst,
  // Data
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta;
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta <= {WIDTH{1'b0}};
      q    <= {WIDTH{1'b0}};
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // sync_2ff
